// ==== host_model.sv ====
// host controller model acting as avalon-mm master of the panel bank
`timescale 1ns/100ps
module host_model
(
  // clock
  input wire i_clk_sys,
  // avalon-mm master
  output reg [7:0] o_address,
  output reg o_read,
  output reg o_write,
  output reg [31:0] o_writedata,
  output reg [3:0] o_byteenable,
  input wire [31:0] i_readdata,
  input wire i_waitrequest
);
  // ------------------------------
  // bus cycles
  // ------------------------------
  initial
  begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h00000000;
    o_byteenable = 4'h0;
  end
  // the host reserves words base+0..7 for the panel
  // request held until waitrequest is sampled low at a rising edge
  task xfer(input w, input [7:0] a, input [15:0] d, input [3:0] be,
    output [31:0] q);
    begin
      @(posedge i_clk_sys);
      o_address <= a;
      o_read <= !w;
      o_write <= w;
      o_writedata <= {16'h0000, d};
      o_byteenable <= be;
      @(posedge i_clk_sys);
      while (i_waitrequest)
        @(posedge i_clk_sys);
      q = i_readdata;
      o_read <= 1'b0;
      o_write <= 1'b0;
      // released lines flip so a stale value never looks live
      o_address <= ~a;
      o_writedata <= ~{16'h0000, d};
    end
  endtask
endmodule

// ==== setpoint_panel_defines.vh ====
// constants for the setpoint panel register bank
`ifndef SETPOINT_PANEL_DEFINES_VH
`define SETPOINT_PANEL_DEFINES_VH

// word groups, decoded from byte address bits [7:5]
`define GRP_DATA 3'h0
`define GRP_CFG 3'h1
`define GRP_LO 3'h2
`define GRP_HI 3'h3
`define GRP_MISC 3'h4

// word indices inside the data group (base plus n)
`define IDX_FORCE_DATA 3'h6
`define IDX_FORCE_CTRL 3'h7
`define LAST_POINT 3'h5

// word indices inside the misc group
`define SUB_CTRL 3'h0
`define SUB_BASE 3'h1
`define SUB_STAT 3'h2

// force control word fields
`define FC_FLAG 15
`define FC_SEL_HI 5

// per point configuration word fields
`define CFG_SETPT 0
`define CFG_BCD 1
`define CFG_DIG_LO 2
`define CFG_DIG_HI 3

// control word fields
`define CTRL_FORCE_EN 0

// value limits and reset values
`define VAL_MAX 16'h270F
`define LIM_LO_RST 16'h0000
`define LIM_HI_RST 16'h270F
`define CFG_RST 4'h0
`define BASE_RST 16'h0000
`define WORD_ZERO 16'h0000

`endif

// ==== setpoint_panel_props.sv ====
// assertions on the ports of the setpoint panel register bank
`timescale 1ns/100ps
module setpoint_panel_props
(
  // clock and reset
  input wire i_clk_sys,
  input wire i_arst_n,
  // bus and panel outputs
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire [2:0] o_disp_point,
  input wire o_force_done
);
  // ------------------------------
  // bus answer, display scan and force timing
  // ------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // a request taken while waitrequest is high
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  // exactly one answer cycle, then waiting again
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_one_wait_state: assert property (s_taken |=> s_answer)
    else $error("bus answer not after one wait cycle");
  a_idle_no_answer: assert property (
    !(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("answer without request");
  a_upper_half_zero: assert property (
    o_avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_rdata_on_read: assert property (
    !$stable(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest))
    else $error("read data moved without a read");
  a_point_in_range: assert property (o_disp_point <= 3'h5)
    else $error("scanned point out of range");
  a_scan_wraps: assert property (
    o_disp_point == 3'h5 |=> o_disp_point == 3'h0)
    else $error("scan did not wrap after last point");
  a_done_one_cycle: assert property (
    o_force_done |=> !o_force_done)
    else $error("force done longer than one cycle");
  // the panel applies a force one edge after the write that starts it and raises done at that edge
  a_done_after_write: assert property (
    $rose(o_force_done) |-> $past(i_avs_write && !o_avs_waitrequest, 2))
    else $error("force done without a preceding write");
endmodule

bind setpoint_panel_register_map setpoint_panel_props setpoint_panel_props_inst
(
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_disp_point(o_disp_point),
  .o_force_done(o_force_done)
);

// ==== setpoint_panel_register_map.v ====
// register bank shared between a setpoint panel and its host controller
`timescale 1ns/100ps
`include "setpoint_panel_defines.vh"

// How it works
// RULE1: host keeps at least eight contiguous words for the panel block
// RULE2: field point n sits at base word plus n minus one
// RULE3: host writes display point values; panel shows them
// RULE4: each point is display or setpoint, binary or BCD, with decimals
// RULE5: panel keeps writing every setpoint value into its word unasked
// RULE6: host loads force data at base plus six, then flag and selects
// RULE7: after a force the panel clears force data and control words
// RULE8: host writes the force command once and lets the panel clear it
// RULE9: a force completes well inside one second
// RULE10: host may poll both force words until they read zero
// RULE11: force commands act only when force is enabled
// RULE12: words are integer data file words of the host
// RULE13: force control holds a flag and six point select bits
// RULE14: values stay within 0..9999 and per point low/high limits
// RULE15: words are 16 bits; selects of display points are ignored
module setpoint_panel_register_map
(
  // clock and reset
  input wire i_clk_sys,
  input wire i_arst_n,
  // avalon-mm slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // operator setpoint entry from panel logic
  input wire i_entry_valid,
  input wire [2:0] i_entry_point,
  input wire [15:0] i_entry_value,
  // display scan towards the digit driver
  output reg [2:0] o_disp_point,
  output reg [15:0] o_disp_value,
  output reg o_disp_bcd,
  output reg [1:0] o_disp_digits,
  output reg o_disp_setpoint,
  // force completion pulse
  output reg o_force_done
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------

  // byte-lane merge of a 16-bit word
  function [15:0] be_merge;
    input [15:0] old_w;
    input [15:0] new_w;
    input [1:0] be;
    begin
      be_merge = old_w;
      if (be[0])
        be_merge[7:0] = new_w[7:0];
      if (be[1])
        be_merge[15:8] = new_w[15:8];
    end
  endfunction

  // four bcd digits to binary; bad digits are left for the clamp
  function [15:0] bcd2bin;
    input [15:0] d;
    begin
      bcd2bin = (({12'h000, d[15:12]} * 16'h03E8)
        + ({12'h000, d[11:8]} * 16'h0064)
        + ({12'h000, d[7:4]} * 16'h000A)
        + {12'h000, d[3:0]});
    end
  endfunction

  // binary (0..9999) to four bcd digits by shift and add three
  function [15:0] bin2bcd;
    input [15:0] b;
    integer k;
    reg [29:0] s;
    begin
      s = {16'h0000, b[13:0]};
      for (k = 0; k < 14; k = k + 1)
      begin
        if (s[17:14] > 4'h4)
          s[17:14] = s[17:14] + 4'h3;
        if (s[21:18] > 4'h4)
          s[21:18] = s[21:18] + 4'h3;
        if (s[25:22] > 4'h4)
          s[25:22] = s[25:22] + 4'h3;
        if (s[29:26] > 4'h4)
          s[29:26] = s[29:26] + 4'h3;
        s = {s[28:0], 1'b0};
      end
      bin2bcd = s[29:14];
    end
  endfunction

  // keep a value inside the point limits and the 0..9999 range
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = v;
      if (clamp > hi)
        clamp = hi;
      if (clamp < lo)
        clamp = lo;
      if (clamp > `VAL_MAX)
        clamp = `VAL_MAX; // see RULE14
    end
  endfunction

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------

  reg [15:0] data_q [0:7];  // base plus 0..7, 16-bit words (see RULE15)
  reg [3:0] cfg_q [0:5];
  reg [15:0] lo_q [0:5];
  reg [15:0] hi_q [0:5];
  reg [15:0] sp_q [0:5];   // setpoints held in binary
  reg force_en_q;
  reg [15:0] base_q;
  reg [15:0] force_cnt_q;
  reg [2:0] scan_q;
  reg [15:0] rd_d;
  integer cfg_n;
  integer sp_n;
  integer word_n;

  wire [2:0] grp = i_avs_address[7:5];
  wire [2:0] sub = i_avs_address[4:2]; // see RULE12
  wire pt_ok = (sub <= `LAST_POINT);
  wire wr_go = i_avs_write & ~o_avs_waitrequest;
  wire [1:0] be = i_avs_byteenable[1:0];
  wire [15:0] wd = i_avs_writedata[15:0];

  // a force runs only with the option on and the flag set
  wire force_go = force_en_q & data_q[`IDX_FORCE_CTRL][`FC_FLAG]; // see RULE11

  // host write landing on a force word in the clearing cycle wins
  wire host_fd = wr_go & (grp == `GRP_DATA) & (sub == `IDX_FORCE_DATA);
  wire host_fc = wr_go & (grp == `GRP_DATA) & (sub == `IDX_FORCE_CTRL);

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------

  // read mux; unmapped words read as zero
  always @*
  begin
    rd_d = `WORD_ZERO;
    case (grp)
      `GRP_DATA:
        rd_d = data_q[sub];
      `GRP_CFG:
        rd_d = pt_ok ? {12'h000, cfg_q[sub]} : `WORD_ZERO;
      `GRP_LO:
        rd_d = pt_ok ? lo_q[sub] : `WORD_ZERO;
      `GRP_HI:
        rd_d = pt_ok ? hi_q[sub] : `WORD_ZERO;
      `GRP_MISC:
        case (sub)
          `SUB_CTRL:
            rd_d = {15'h0000, force_en_q};
          `SUB_BASE:
            rd_d = base_q;
          `SUB_STAT:
            rd_d = force_cnt_q;
          default:
            rd_d = `WORD_ZERO;
        endcase
      default:
        rd_d = `WORD_ZERO;
    endcase
  end

  // one wait cycle per access; waitrequest idles high
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end
    else if ((i_avs_read | i_avs_write) & o_avs_waitrequest)
    begin
      o_avs_waitrequest <= 1'b0;
      if (i_avs_read)
        o_avs_readdata <= {16'h0000, rd_d};
    end
    else
      o_avs_waitrequest <= 1'b1;
  end

  // ------------------------------------------------------------
  // configuration words
  // ------------------------------------------------------------

  // type, format and decimals per point, plus limits (see RULE4)
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (cfg_n = 0; cfg_n < 6; cfg_n = cfg_n + 1)
      begin
        cfg_q[cfg_n] <= `CFG_RST;
        lo_q[cfg_n] <= `LIM_LO_RST;
        hi_q[cfg_n] <= `LIM_HI_RST;
      end
      force_en_q <= 1'b0;
      base_q <= `BASE_RST;
    end
    else if (wr_go)
    begin
      if (grp == `GRP_CFG && pt_ok && be[0])
        cfg_q[sub] <= wd[3:0];
      if (grp == `GRP_LO && pt_ok)
        lo_q[sub] <= be_merge(lo_q[sub], wd, be); // see RULE14
      if (grp == `GRP_HI && pt_ok)
        hi_q[sub] <= be_merge(hi_q[sub], wd, be); // see RULE14
      if (grp == `GRP_MISC && sub == `SUB_CTRL && be[0])
        force_en_q <= wd[`CTRL_FORCE_EN]; // see RULE11
      if (grp == `GRP_MISC && sub == `SUB_BASE)
        base_q <= be_merge(base_q, wd, be); // see RULE2
    end
  end

  // ------------------------------------------------------------
  // setpoints
  // ------------------------------------------------------------

  // force beats operator entry in the same cycle; values are clamped
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (sp_n = 0; sp_n < 6; sp_n = sp_n + 1)
        sp_q[sp_n] <= `WORD_ZERO;
    end
    else if (force_go)
    begin
      // selects of display points are dropped (see RULE15)
      for (sp_n = 0; sp_n <= `FC_SEL_HI; sp_n = sp_n + 1)
        if (data_q[`IDX_FORCE_CTRL][sp_n] && cfg_q[sp_n][`CFG_SETPT])
          sp_q[sp_n] <= clamp(cfg_q[sp_n][`CFG_BCD] ?
            bcd2bin(data_q[`IDX_FORCE_DATA]) :
            data_q[`IDX_FORCE_DATA], lo_q[sp_n], hi_q[sp_n]); // see RULE13
    end
    else if (i_entry_valid && i_entry_point <= `LAST_POINT)
    begin
      if (cfg_q[i_entry_point][`CFG_SETPT])
        sp_q[i_entry_point] <= clamp(i_entry_value,
          lo_q[i_entry_point], hi_q[i_entry_point]); // see RULE14
    end
  end

  // ------------------------------------------------------------
  // shared words and scan
  // ------------------------------------------------------------

  // scan one point per cycle, so every setpoint is refreshed every
  // six cycles; host writes land last and win over panel updates
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (word_n = 0; word_n < 8; word_n = word_n + 1)
        data_q[word_n] <= `WORD_ZERO;
      scan_q <= 3'h0;
      force_cnt_q <= `WORD_ZERO;
      o_force_done <= 1'b0;
    end
    else
    begin
      scan_q <= (scan_q == `LAST_POINT) ? 3'h0 : scan_q + 3'h1;
      if (cfg_q[scan_q][`CFG_SETPT])
        data_q[scan_q] <= cfg_q[scan_q][`CFG_BCD] ?
          bin2bcd(sp_q[scan_q]) : sp_q[scan_q]; // see RULE5
      // completion is one cycle after the flag shows (see RULE9)
      o_force_done <= force_go;
      if (force_go)
      begin
        data_q[`IDX_FORCE_DATA] <= `WORD_ZERO; // see RULE7
        data_q[`IDX_FORCE_CTRL] <= `WORD_ZERO; // see RULE7
        force_cnt_q <= force_cnt_q + 16'h0001;
      end
      // display words come only from the host (see RULE3)
      if (wr_go && grp == `GRP_DATA)
        data_q[sub] <= be_merge(data_q[sub], wd, be); // see RULE2
      if (force_go && host_fd)
        data_q[`IDX_FORCE_DATA] <= be_merge(`WORD_ZERO, wd, be);
      if (force_go && host_fc)
        data_q[`IDX_FORCE_CTRL] <= be_merge(`WORD_ZERO, wd, be);
    end
  end

  // display outputs follow the scan, raw word plus its format
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_disp_point <= 3'h0;
      o_disp_value <= `WORD_ZERO;
      o_disp_bcd <= 1'b0;
      o_disp_digits <= 2'h0;
      o_disp_setpoint <= 1'b0;
    end
    else
    begin
      o_disp_point <= scan_q;
      o_disp_value <= data_q[scan_q]; // see RULE3
      o_disp_bcd <= cfg_q[scan_q][`CFG_BCD]; // see RULE4
      o_disp_digits <= cfg_q[scan_q][`CFG_DIG_HI:`CFG_DIG_LO];
      o_disp_setpoint <= cfg_q[scan_q][`CFG_SETPT];
    end
  end

endmodule

// ==== setpoint_panel_register_map_tb_top.sv ====
// self-checking bench for the setpoint panel register bank
`timescale 1ns/100ps
module setpoint_panel_register_map_tb_top;
  // ------------------------------
  // clock, reset and wiring
  // ------------------------------
  reg i_clk_sys;
  reg i_arst_n;
  reg entry_valid;
  reg [2:0] entry_point;
  reg [15:0] entry_value;
  wire [7:0] address;
  wire read;
  wire write;
  wire [31:0] writedata;
  wire [3:0] byteenable;
  wire [31:0] readdata;
  wire waitrequest;
  wire [2:0] disp_point;
  wire [15:0] disp_value;
  wire disp_bcd;
  wire [1:0] disp_digits;
  wire disp_setpoint;
  integer error_cnt;
  integer check_count;
  integer n;
  reg [31:0] q;
  host_model host_model_inst
  (
    .i_clk_sys(i_clk_sys), .o_address(address), .o_read(read),
    .o_write(write), .o_writedata(writedata), .o_byteenable(byteenable),
    .i_readdata(readdata), .i_waitrequest(waitrequest)
  );
  setpoint_panel_register_map setpoint_panel_register_map_inst
  (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_avs_address(address),
    .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
    .i_avs_byteenable(byteenable), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitrequest), .i_entry_valid(entry_valid),
    .i_entry_point(entry_point), .i_entry_value(entry_value),
    .o_disp_point(disp_point), .o_disp_value(disp_value),
    .o_disp_bcd(disp_bcd), .o_disp_digits(disp_digits),
    .o_disp_setpoint(disp_setpoint), .o_force_done()
  );
  // free running clock, 100 ns period
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d, input [3:0] be);
    host_model_inst.xfer(1'b1, a, d, be, q);
  endtask
  task rc(input [7:0] a, input [15:0] e);
    begin
      host_model_inst.xfer(1'b0, a, 16'h0000, 4'hF, q);
      chk(q, {16'h0000, e});
    end
  endtask
  // one operator entry; the scan needs at most six cycles to publish it
  task ent(input [2:0] p, input [15:0] v);
    begin
      @(posedge i_clk_sys);
      entry_valid <= 1'b1;
      entry_point <= p;
      entry_value <= v;
      @(posedge i_clk_sys);
      entry_valid <= 1'b0;
      repeat (8) @(posedge i_clk_sys);
    end
  endtask
  task stop_test;
    begin
      if (error_cnt == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // watchdog far beyond the 150 or so cycles the tests need
  initial
  begin
    #2000000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    i_arst_n = 1'b0;
    entry_valid = 1'b0;
    entry_point = 3'h0;
    entry_value = 16'h0000;
    repeat (4) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    rc(8'h60, 16'h270F);
    rc(8'h80, 16'h0000);
    wr(8'hFC, 16'h5A5A, 4'hF);
    rc(8'hFC, 16'h0000);
    // display point keeps host data; lanes switched off keep old bits
    wr(8'h04, 16'h1234, 4'hF);
    wr(8'h04, 16'hABCD, 4'h1);
    rc(8'h04, 16'h12CD);
    // setpoint word is republished by the scan over host writes
    wr(8'h20, 16'h0001, 4'hF);
    ent(3'h0, 16'h0064);
    rc(8'h00, 16'h0064);
    wr(8'h00, 16'h0055, 4'hF);
    repeat (8) @(posedge i_clk_sys);
    rc(8'h00, 16'h0064);
    ent(3'h0, 16'h2EE0);
    rc(8'h00, 16'h270F);
    // force while disabled stays pending, then runs once enabled
    wr(8'h18, 16'h0007, 4'hF);
    wr(8'h1C, 16'h8001, 4'hF);
    rc(8'h1C, 16'h8001);
    rc(8'h88, 16'h0000);
    wr(8'h80, 16'h0001, 4'hF);
    rc(8'h18, 16'h0000);
    rc(8'h1C, 16'h0000);
    rc(8'h00, 16'h0007);
    // bcd point four forced; select of display point two ignored
    wr(8'h2C, 16'h000B, 4'hF);
    wr(8'h18, 16'h4321, 4'hF);
    wr(8'h1C, 16'h800A, 4'hF);
    q = 32'h00000001;
    for (n = 0; n < 10 && q !== 32'h00000000; n = n + 1)
      host_model_inst.xfer(1'b0, 8'h1C, 16'h0000, 4'hF, q);
    chk(q, 32'h00000000);
    // the scan may need six cycles to republish point four
    repeat (6) @(posedge i_clk_sys);
    rc(8'h0C, 16'h4321);
    // display scan shows point four as bcd setpoint, two decimals
    for (n = 0; n < 8 && disp_point !== 3'h3; n = n + 1)
      @(posedge i_clk_sys);
    chk(disp_point, 3'h3);
    chk(disp_value, 16'h4321);
    chk({disp_setpoint, disp_bcd, disp_digits}, 4'hE);
    rc(8'h04, 16'h12CD);
    // point two kept no setpoint from the force or from an entry
    ent(3'h1, 16'h0099);
    wr(8'h24, 16'h0001, 4'hF);
    repeat (8) @(posedge i_clk_sys);
    rc(8'h04, 16'h0000);
    wr(8'h88, 16'h0005, 4'hF);
    rc(8'h88, 16'h0002);
    stop_test;
  end
endmodule
